/* logic/pfc_flow_ctrl.sv */
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module pfc_flow_ctrl
  import pfc_pkg::*;
#(
  parameter logic [15:0] RAM_BASE = 16'h0000,
  parameter logic [15:0] RAM_LAST = 16'h07FF,
  parameter int unsigned SRC_SWITCH_CYCLES = 3200,
  parameter int unsigned WAKE_BASE_CYCLES = 256
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [3:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_we,
  input wire logic i_reg_re,
  output logic [7:0] o_reg_rdata,
  input wire logic i_op_valid,
  input wire pfc_op_t i_op,
  input wire logic [15:0] i_operand,
  input wire logic i_skip_cond,
  input wire logic i_skip_ext,
  input wire logic i_irq,
  input wire logic [15:0] i_ret_addr,
  input wire logic i_reti_keep_speed,
  input wire logic i_exec_from_flash,
  input wire logic [2:0] i_fuse_osc_wakeup,
  input wire logic [2:0] i_fuse_mult_wakeup,
  output logic o_core_tick,
  output logic o_ready,
  output logic [15:0] o_pc,
  output logic [2:0] o_page_select_bits,
  output logic [1:0] o_clock_source,
  output logic o_osc_off,
  output logic o_mult_off,
  output logic o_in_isr,
  output logic o_flash_rd,
  output logic [15:0] o_flash_addr,
  input wire logic i_flash_rvalid,
  input wire logic [15:0] i_flash_rdata,
  output logic o_ram_wr,
  output logic o_ram_rd,
  output logic [15:0] o_ram_addr,
  output logic [15:0] o_ram_wdata,
  input wire logic [15:0] i_ram_rdata
);
  localparam int WAKE_W = 24;
  if (RAM_LAST < RAM_BASE) begin : g_ram_check
    $error("RAM range is empty");
  end
  if (WAKE_BASE_CYCLES * 128 >= (1 << WAKE_W)) begin : g_wake_check
    $error("Wake-up delay too long for counter");
  end
  if (SRC_SWITCH_CYCLES >= (1 << WAKE_W)) begin : g_src_check
    $error("Source switch delay too long for counter");
  end
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  pfc_state_t state, next_state;
  logic [1:0] busy_cnt, next_busy_cnt;
  logic [15:0] pc, next_pc;
  logic [2:0] page_select_bits, next_page_select_bits;
  logic [2:0] page_shadow, next_page_shadow;
  logic [7:0] current_speed_reg, next_current_speed_reg;
  logic [7:0] speed_shadow, next_speed_shadow;
  logic [7:0] isr_speed_reg, next_isr_speed_reg;
  logic [7:0] prog_addr_high, next_prog_addr_high;
  logic [7:0] prog_addr_low, next_prog_addr_low;
  logic [7:0] prog_data_high, next_prog_data_high;
  logic [7:0] prog_data_low, next_prog_data_low;
  logic [7:0] vector_high_reg, next_vector_high_reg;
  logic [7:0] vector_low_reg, next_vector_low_reg;
  logic in_isr, next_in_isr;
  logic fread_pend, next_fread_pend;
  logic flash_rd, next_flash_rd;
  logic ram_wr, next_ram_wr;
  logic ram_rd, next_ram_rd;
  logic ram_rd_q, next_ram_rd_q;
  logic [7:0] rdata, next_rdata;
  logic [7:0] div_cnt, next_div_cnt;
  logic [WAKE_W-1:0] wake_cnt, next_wake_cnt;
  // ----------------------------------------------------------------
  // Core clock enable
  // ----------------------------------------------------------------
  logic [15:0] prog_addr;
  logic [7:0] eff_div;
  logic stopped, tick, accept, take_irq, spd_event, in_ram;
  logic [8:0] pcl_sum;
  assign prog_addr = {prog_addr_high, prog_addr_low};
  assign in_ram = (prog_addr >= RAM_BASE) && (prog_addr <= RAM_LAST);
  always_comb begin
    eff_div = pfc_div(current_speed_reg[DIV_HI:DIV_LO]);
    if (i_exec_from_flash && eff_div < FLASH_DIV) begin
      eff_div = FLASH_DIV;
    end
  end
  // Speed register keeps the programmed value; override lives in eff_div
  assign stopped = (current_speed_reg[DIV_HI:DIV_LO] == DIV_STOP) ||
                   (current_speed_reg[SRC_HI:SRC_LO] == SRC_NONE);
  // Ticks are held off while a source settles, so no short core pulse
  // At least, not equal: a divisor that shrinks mid-count must not wrap
  assign tick = !stopped && (wake_cnt == '0) &&
                (div_cnt >= eff_div - 8'h01);
  assign accept = tick && (state == ST_RUN);
  assign take_irq = tick && i_irq &&
                    ((state == ST_RUN) || (state == ST_SKIP));
  assign pcl_sum = {1'b0, pc[7:0]} + {1'b0, i_operand[7:0]} +
                   {8'h00, i_operand[8]};
  assign o_core_tick = tick;
  assign o_ready = accept && !i_irq;
  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] old_spd;
    logic [7:0] new_spd;
    logic [31:0] wait_cyc;
    old_spd = current_speed_reg;
    new_spd = current_speed_reg;
    wait_cyc = 32'h0000_0000;
    next_state = state;
    next_busy_cnt = busy_cnt;
    next_pc = pc;
    next_page_select_bits = page_select_bits;
    next_page_shadow = page_shadow;
    next_current_speed_reg = current_speed_reg;
    next_speed_shadow = speed_shadow;
    next_isr_speed_reg = isr_speed_reg;
    next_prog_addr_high = prog_addr_high;
    next_prog_addr_low = prog_addr_low;
    next_prog_data_high = prog_data_high;
    next_prog_data_low = prog_data_low;
    next_vector_high_reg = vector_high_reg;
    next_vector_low_reg = vector_low_reg;
    next_in_isr = in_isr;
    next_fread_pend = fread_pend;
    next_flash_rd = 1'b0;
    next_ram_wr = 1'b0;
    next_ram_rd = 1'b0;
    next_ram_rd_q = ram_rd;
    next_rdata = rdata;
    spd_event = 1'b0;
    // Software side
    if (i_reg_we) begin
      case (i_reg_addr)
        REG_ADDR_LOW: next_prog_addr_low = i_reg_wdata;
        REG_ADDR_HIGH: next_prog_addr_high = i_reg_wdata;
        REG_DATA_LOW: next_prog_data_low = i_reg_wdata;
        REG_DATA_HIGH: next_prog_data_high = i_reg_wdata;
        REG_COUNTER_LOW: next_pc = {pc[15:8], i_reg_wdata};
        REG_ISR_SPEED: next_isr_speed_reg = i_reg_wdata;
        REG_VECTOR_LOW: next_vector_low_reg = i_reg_wdata;
        REG_VECTOR_HIGH: next_vector_high_reg = i_reg_wdata;
        default: ;
      endcase
    end
    if (i_reg_re) begin
      case (i_reg_addr)
        REG_ADDR_LOW: next_rdata = prog_addr_low;
        REG_ADDR_HIGH: next_rdata = prog_addr_high;
        REG_DATA_LOW: next_rdata = prog_data_low;
        REG_DATA_HIGH: next_rdata = prog_data_high;
        REG_COUNTER_LOW: next_rdata = pc[7:0];
        REG_COUNTER_HIGH: next_rdata = pc[15:8];
        REG_CUR_SPEED: next_rdata = current_speed_reg;
        REG_ISR_SPEED: next_rdata = isr_speed_reg;
        REG_VECTOR_LOW: next_rdata = vector_low_reg;
        REG_VECTOR_HIGH: next_rdata = vector_high_reg;
        REG_PAGE: next_rdata = {5'h00, page_select_bits};
        default: next_rdata = 8'h00;
      endcase
    end
    // Hardware loads win over a software write in the same cycle
    if (fread_pend && i_flash_rvalid) begin
      next_prog_data_high = i_flash_rdata[15:8];
      next_prog_data_low = i_flash_rdata[7:0];
      next_fread_pend = 1'b0;
    end
    if (ram_rd_q) begin
      next_prog_data_high = i_ram_rdata[15:8];
      next_prog_data_low = i_ram_rdata[7:0];
    end
    // Instruction flow
    if (take_irq) begin
      next_in_isr = 1'b1;
      next_pc = {vector_high_reg, vector_low_reg};
      next_page_shadow = page_select_bits;
      next_page_select_bits = vector_high_reg[7:5];
      next_speed_shadow = current_speed_reg;
      new_spd = isr_speed_reg;
      spd_event = 1'b1;
      next_state = ST_BUSY;
      next_busy_cnt = BRANCH_REFILL;
    end else if (accept && i_op_valid) begin
      next_pc = pc + 16'h0001;
      case (i_op)
        OP_JMP, OP_CALL: begin
          next_pc = {page_select_bits, i_operand[JUMP_W-1:0]};
          next_state = ST_BUSY;
          next_busy_cnt = BRANCH_REFILL;
        end
        OP_RET: begin
          next_pc = i_ret_addr;
          next_state = ST_BUSY;
          next_busy_cnt = BRANCH_REFILL;
        end
        OP_RETI: begin
          next_pc = i_ret_addr;
          next_in_isr = 1'b0;
          next_page_select_bits = page_shadow;
          if (!i_reti_keep_speed) begin
            new_spd = speed_shadow;
          end
          spd_event = 1'b1;
          next_state = ST_BUSY;
          next_busy_cnt = BRANCH_REFILL;
        end
        OP_SPEED: begin
          new_spd = i_operand[7:0];
          spd_event = 1'b1;
        end
        OP_PAGE: begin
          next_page_select_bits = i_operand[PAGE_W-1:0];
        end
        OP_SKIP: begin
          if (i_skip_cond) begin
            next_state = ST_SKIP;
            next_busy_cnt = SKIP_ONE;
          end
        end
        OP_IREAD: begin
          next_ram_rd = 1'b1;
          next_state = ST_BUSY;
          next_busy_cnt = IRW_EXTRA;
        end
        OP_IWRITE: begin
          next_ram_wr = in_ram;
          next_state = ST_BUSY;
          next_busy_cnt = IRW_EXTRA;
        end
        OP_FREAD: begin
          next_flash_rd = 1'b1;
          next_fread_pend = 1'b1;
        end
        OP_ADD_PCL: begin
          // Carry into the high byte may leave the page bits stale
          next_pc = {pc[15:8] + {7'h00, pcl_sum[8]}, pcl_sum[7:0]};
        end
        default: ;
      endcase
    end else if (tick) begin
      case (state)
        ST_BUSY: begin
          next_busy_cnt = busy_cnt - 2'h1;
          if (busy_cnt == 2'h1) next_state = ST_RUN;
        end
        ST_SKIP: begin
          next_pc = pc + 16'h0001;
          // A skipped page or load op drags the next word along
          if (!i_skip_ext) next_state = ST_RUN;
        end
        default: ;
      endcase
    end
    next_current_speed_reg = new_spd;
    if (old_spd[OSC_OFF] && !new_spd[OSC_OFF]) begin
      wait_cyc = WAKE_BASE_CYCLES << i_fuse_osc_wakeup;
    end else if (old_spd[MULT_OFF] && !new_spd[MULT_OFF]) begin
      wait_cyc = WAKE_BASE_CYCLES << i_fuse_mult_wakeup;
    end else if (old_spd[SRC_HI:SRC_LO] != new_spd[SRC_HI:SRC_LO]) begin
      wait_cyc = SRC_SWITCH_CYCLES;
    end
    if (wait_cyc != 32'h0000_0000) begin
      next_wake_cnt = wait_cyc[WAKE_W-1:0];
    end else if (wake_cnt != '0) begin
      next_wake_cnt = wake_cnt - 1'b1;
    end else begin
      next_wake_cnt = wake_cnt;
    end
    // A new divisor restarts the count at once, with no delay
    if (tick || (new_spd != old_spd) || stopped) begin
      next_div_cnt = 8'h00;
    end else if (wake_cnt != '0) begin
      next_div_cnt = div_cnt;
    end else begin
      next_div_cnt = div_cnt + 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state <= ST_RUN;
      busy_cnt <= 2'h0;
      pc <= 16'h0000;
      page_select_bits <= 3'h0;
      page_shadow <= 3'h0;
      current_speed_reg <= SPEED_RESET;
      speed_shadow <= SPEED_RESET;
      isr_speed_reg <= SPEED_RESET;
      prog_addr_high <= 8'h00;
      prog_addr_low <= 8'h00;
      prog_data_high <= 8'h00;
      prog_data_low <= 8'h00;
      vector_high_reg <= 8'h00;
      vector_low_reg <= 8'h00;
      in_isr <= 1'b0;
      fread_pend <= 1'b0;
      flash_rd <= 1'b0;
      ram_wr <= 1'b0;
      ram_rd <= 1'b0;
      ram_rd_q <= 1'b0;
      rdata <= 8'h00;
      div_cnt <= 8'h00;
      wake_cnt <= '0;
    end else begin
      state <= next_state;
      busy_cnt <= next_busy_cnt;
      pc <= next_pc;
      page_select_bits <= next_page_select_bits;
      page_shadow <= next_page_shadow;
      current_speed_reg <= next_current_speed_reg;
      speed_shadow <= next_speed_shadow;
      isr_speed_reg <= next_isr_speed_reg;
      prog_addr_high <= next_prog_addr_high;
      prog_addr_low <= next_prog_addr_low;
      prog_data_high <= next_prog_data_high;
      prog_data_low <= next_prog_data_low;
      vector_high_reg <= next_vector_high_reg;
      vector_low_reg <= next_vector_low_reg;
      in_isr <= next_in_isr;
      fread_pend <= next_fread_pend;
      flash_rd <= next_flash_rd;
      ram_wr <= next_ram_wr;
      ram_rd <= next_ram_rd;
      ram_rd_q <= next_ram_rd_q;
      rdata <= next_rdata;
      div_cnt <= next_div_cnt;
      wake_cnt <= next_wake_cnt;
    end
  end
  assign o_reg_rdata = rdata;
  assign o_pc = pc;
  assign o_page_select_bits = page_select_bits;
  assign o_clock_source = current_speed_reg[SRC_HI:SRC_LO];
  assign o_osc_off = current_speed_reg[OSC_OFF];
  assign o_mult_off = current_speed_reg[MULT_OFF];
  assign o_in_isr = in_isr;
  assign o_flash_rd = flash_rd;
  assign o_flash_addr = prog_addr;
  assign o_ram_wr = ram_wr;
  assign o_ram_rd = ram_rd;
  assign o_ram_addr = prog_addr;
  assign o_ram_wdata = {prog_data_high, prog_data_low};
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic acc_op;
  assign acc_op = accept && i_op_valid && !i_irq;
  a_pc_carry: assert property (
    acc_op && i_op == OP_ADD_PCL && pcl_sum[8]
    |=> pc[15:8] == $past(pc[15:8]) + 8'h01)
    else $error("High byte not bumped on carry");
  a_jump_page: assert property (
    acc_op && i_op == OP_JMP
    |=> pc == {$past(page_select_bits), $past(i_operand[JUMP_W-1:0])})
    else $error("Jump target not built from page bits");
  a_branch_refill: assert property (
    acc_op && i_op == OP_CALL
    |=> state == ST_BUSY && busy_cnt == BRANCH_REFILL)
    else $error("Branch refill count wrong");
  a_speed_cause: assert property (
    $changed(current_speed_reg) |-> $past(spd_event))
    else $error("Current speed changed without cause");
  a_flash_slow: assert property (
    i_exec_from_flash |-> eff_div >= FLASH_DIV)
    else $error("Flash execution too fast");
  a_clock_off: assert property (
    current_speed_reg[DIV_HI:DIV_LO] == DIV_STOP ||
    current_speed_reg[SRC_HI:SRC_LO] == SRC_NONE |-> !o_core_tick)
    else $error("Core ticks while clock off");
  a_wake_quiet: assert property (
    wake_cnt != '0 |-> !o_core_tick)
    else $error("Core ticks during wake-up");
  a_ram_range: assert property (
    o_ram_wr |-> o_ram_addr >= RAM_BASE && o_ram_addr <= RAM_LAST)
    else $error("RAM write outside program RAM");
  a_fread_bytes: assert property (
    fread_pend && i_flash_rvalid
    |=> prog_data_high == $past(i_flash_rdata[15:8])
        && prog_data_low == $past(i_flash_rdata[7:0]))
    else $error("Flash word bytes misplaced");
  a_isr_page: assert property (
    take_irq |=> page_select_bits == $past(vector_high_reg[7:5]) && in_isr)
    else $error("Page bits not loaded on interrupt");
  a_irw_cycles: assert property (
    acc_op && i_op == OP_IWRITE
    |=> state == ST_BUSY && busy_cnt == IRW_EXTRA)
    else $error("RAM write length wrong");
  a_skip_none: assert property (
    acc_op && i_op == OP_SKIP && !i_skip_cond |=> state == ST_RUN)
    else $error("Untaken skip stalled");
  c_speed_op: cover property (acc_op && i_op == OP_SPEED);
  c_irq_taken: cover property (take_irq ##[1:300] acc_op && i_op == OP_RETI);
  c_ext_skip: cover property (state == ST_SKIP && tick && i_skip_ext);
  c_iwrite: cover property (o_ram_wr);
endmodule
`default_nettype wire

/* logic/pfc_pkg.sv */
`default_nettype none
package pfc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FLASH_ACCESS_NS = 25;
  localparam int unsigned FLASH_DIV_CYC =
    (FLASH_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] FLASH_DIV = 8'(FLASH_DIV_CYC);
  localparam logic [1:0] BRANCH_REFILL = 2'h2;
  localparam logic [1:0] IRW_EXTRA = 2'h3;
  localparam logic [1:0] SKIP_ONE = 2'h1;
  // ----------------------------------------------------------------
  // Register indexes
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_ADDR_LOW = 4'h0;
  localparam logic [3:0] REG_ADDR_HIGH = 4'h1;
  localparam logic [3:0] REG_DATA_LOW = 4'h2;
  localparam logic [3:0] REG_DATA_HIGH = 4'h3;
  localparam logic [3:0] REG_COUNTER_LOW = 4'h4;
  localparam logic [3:0] REG_COUNTER_HIGH = 4'h5;
  localparam logic [3:0] REG_CUR_SPEED = 4'h6;
  localparam logic [3:0] REG_ISR_SPEED = 4'h7;
  localparam logic [3:0] REG_VECTOR_LOW = 4'h8;
  localparam logic [3:0] REG_VECTOR_HIGH = 4'h9;
  localparam logic [3:0] REG_PAGE = 4'hA;
  // ----------------------------------------------------------------
  // Speed register layout and codes
  // ----------------------------------------------------------------
  localparam int DIV_HI = 7;
  localparam int DIV_LO = 4;
  localparam int SRC_HI = 3;
  localparam int SRC_LO = 2;
  localparam int MULT_OFF = 1;
  localparam int OSC_OFF = 0;
  localparam logic [7:0] SPEED_RESET = 8'h00;
  localparam logic [3:0] DIV_STOP = 4'hF;
  localparam logic [1:0] SRC_MULT = 2'h0;
  localparam logic [1:0] SRC_OSC = 2'h1;
  localparam logic [1:0] SRC_RTC = 2'h2;
  localparam logic [1:0] SRC_NONE = 2'h3;
  localparam int JUMP_W = 13;
  localparam int PAGE_W = 3;
  typedef enum logic [3:0] {
    OP_NOP, OP_JMP, OP_CALL, OP_RET, OP_RETI, OP_SPEED, OP_PAGE,
    OP_SKIP, OP_IREAD, OP_IWRITE, OP_FREAD, OP_MUL, OP_ADD_PCL
  } pfc_op_t;
  typedef enum logic [2:0] {
    ST_RUN = 3'h1, ST_BUSY = 3'h2, ST_SKIP = 3'h4
  } pfc_state_t;
  function automatic logic [7:0] pfc_div(input logic [3:0] code);
    case (code)
      4'h0: pfc_div = 8'h01;
      4'h1: pfc_div = 8'h02;
      4'h2: pfc_div = 8'h03;
      4'h3: pfc_div = 8'h04;
      4'h4: pfc_div = 8'h05;
      4'h5: pfc_div = 8'h06;
      4'h6: pfc_div = 8'h08;
      4'h7: pfc_div = 8'h0A;
      4'h8: pfc_div = 8'h0C;
      4'h9: pfc_div = 8'h10;
      4'hA: pfc_div = 8'h18;
      4'hB: pfc_div = 8'h20;
      4'hC: pfc_div = 8'h30;
      4'hD: pfc_div = 8'h40;
      4'hE: pfc_div = 8'h80;
      default: pfc_div = 8'h01;
    endcase
  endfunction
endpackage
`default_nettype wire

/* sim/pfc_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Program flash and program RAM on the far side
// ------------------------------------------------------------
module pfc_mem_model #(
  parameter int FLASH_LAT = 3
) (
  input wire logic i_clk,
  input wire logic i_flash_rd,
  input wire logic [15:0] i_flash_addr,
  output logic o_flash_rvalid,
  output logic [15:0] o_flash_rdata,
  input wire logic i_ram_wr,
  input wire logic i_ram_rd,
  input wire logic [15:0] i_ram_addr,
  input wire logic [15:0] i_ram_wdata,
  output logic [15:0] o_ram_rdata
);
  logic [15:0] ram [0:2047];
  logic [15:0] fa = 16'h0000;
  int cnt = 0;
  initial begin
    o_flash_rvalid = 1'b0;
    o_flash_rdata = 16'h0000;
    o_ram_rdata = 16'h0000;
  end
  // Buses toggle outside their answer cycle so stale data never passes
  always @(posedge i_clk) begin
    o_flash_rvalid <= 1'b0;
    o_flash_rdata <= ~o_flash_rdata;
    o_ram_rdata <= ~o_ram_rdata;
    if (i_flash_rd) begin
      cnt <= FLASH_LAT;
      fa <= i_flash_addr;
    end else if (cnt == 1) begin
      cnt <= 0;
      o_flash_rvalid <= 1'b1;
      o_flash_rdata <= fa ^ 16'h5AC3;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
    if (i_ram_wr) ram[i_ram_addr[10:0]] <= i_ram_wdata;
    if (i_ram_rd) o_ram_rdata <= ram[i_ram_addr[10:0]];
  end
endmodule
`default_nettype wire

/* sim/test_cpu_program_flow_speed_control.sv */
`timescale 1ns/1ns
`default_nettype none
module test_cpu_program_flow_speed_control;
  import pfc_pkg::*;
  logic clk, reset, we, re, opv, sc, irq, keep, ffl, rdy, isr;
  logic fr, fv, rw, rr, sx, tk, oo, mo;
  logic [3:0] ra;
  logic [7:0] wd, rdata;
  logic [2:0] pg;
  logic [1:0] src;
  logic [15:0] opnd, ret, pc, fa, fd, ma, mw, md;
  pfc_op_t opk;
  int n_mismatch = 0, tests_run = 0, cyc = 0, n_wr = 0;
  int dv[15] = '{1, 2, 3, 4, 5, 6, 8, 10, 12, 16, 24, 32, 48, 64, 128};
  // ------------------------------------------------------------
  // Design and far side
  // ------------------------------------------------------------
  pfc_flow_ctrl #(.SRC_SWITCH_CYCLES(4), .WAKE_BASE_CYCLES(2)) u_dut (
    .i_clk(clk), .i_reset(reset), .i_reg_addr(ra), .i_reg_wdata(wd),
    .i_reg_we(we), .i_reg_re(re), .o_reg_rdata(rdata), .i_op_valid(opv),
    .i_op(opk), .i_operand(opnd), .i_skip_cond(sc), .i_skip_ext(sx),
    .i_irq(irq), .i_ret_addr(ret), .i_reti_keep_speed(keep),
    .i_exec_from_flash(ffl), .i_fuse_osc_wakeup(3'h1),
    .i_fuse_mult_wakeup(3'h2), .o_core_tick(tk), .o_ready(rdy), .o_pc(pc),
    .o_page_select_bits(pg), .o_clock_source(src), .o_osc_off(oo),
    .o_mult_off(mo), .o_in_isr(isr), .o_flash_rd(fr), .o_flash_addr(fa),
    .i_flash_rvalid(fv), .i_flash_rdata(fd), .o_ram_wr(rw), .o_ram_rd(rr),
    .o_ram_addr(ma), .o_ram_wdata(mw), .i_ram_rdata(md));
  pfc_mem_model u_mem (.i_clk(clk), .i_flash_rd(fr), .i_flash_addr(fa),
    .o_flash_rvalid(fv), .o_flash_rdata(fd), .i_ram_wr(rw), .i_ram_rd(rr),
    .i_ram_addr(ma), .i_ram_wdata(mw), .o_ram_rdata(md));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (rw) n_wr <= n_wr + 1;
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("Compares %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input string nm);
    n_mismatch++;
    $display("Error %s expected done seen timeout", nm);
    stop_test();
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1; ra <= a; wd <= d;
    @(posedge clk);
    we <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e, string nm);
    @(posedge clk);
    re <= 1'b1; ra <= a;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    chk(nm, {8'h00, e}, {8'h00, rdata});
  endtask
  // Slow dividers stretch the wait, so the bound covers divide by 128
  task automatic wait_rdy;
    cyc = 0;
    do begin
      @(negedge clk);
      cyc++;
    end while (rdy !== 1'b1 && cyc < 600);
    if (cyc >= 600) hang("ready");
  endtask
  task automatic op(input pfc_op_t k, input logic [15:0] v);
    @(posedge clk);
    opk <= k; opnd <= v; opv <= 1'b1;
    wait_rdy();
    @(posedge clk);
    opv <= 1'b0;
    wait_rdy();
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    rdchk(REG_CUR_SPEED, SPEED_RESET, "speed reset");
    wr(REG_CUR_SPEED, 8'h55);
    rdchk(REG_CUR_SPEED, 8'h00, "speed write");
    wr(REG_ISR_SPEED, 8'hA6);
    rdchk(REG_ISR_SPEED, 8'hA6, "isr speed");
    rdchk(4'hF, 8'h00, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_branch;
    logic [15:0] p0;
    op(OP_PAGE, 16'h0001);
    op(OP_JMP, 16'h0123);
    chk("jmp pc", 16'h2123, pc);
    chk("jmp cycles", 16'h3, 16'(cyc));
    op(OP_CALL, 16'h0040);
    chk("call pc", 16'h2040, pc);
    chk("call cycles", 16'h3, 16'(cyc));
    op(OP_RET, 16'h0000);
    chk("ret pc", 16'h2150, pc);
    chk("ret cycles", 16'h3, 16'(cyc));
    wr(REG_COUNTER_LOW, 8'hF0);
    chk("pc low write", 16'h21F0, pc);
    wr(REG_COUNTER_HIGH, 8'h77);
    rdchk(REG_COUNTER_HIGH, 8'h21, "pc high");
    op(OP_ADD_PCL, 16'h0020);
    chk("add carry pc", 16'h2210, pc);
    op(OP_JMP, 16'h0005);
    chk("page jmp pc", 16'h2005, pc);
    @(posedge clk);
    sc <= 1'b1;
    op(OP_SKIP, 16'h0000);
    chk("skip taken", 16'h2, 16'(cyc));
    p0 = pc;
    @(posedge clk);
    sx <= 1'b1;
    opk <= OP_SKIP;
    opv <= 1'b1;
    wait_rdy();
    @(posedge clk);
    opv <= 1'b0;
    @(posedge clk);
    sx <= 1'b0;
    wait_rdy();
    chk("ext skip pc", p0 + 16'h0003, pc);
    @(posedge clk);
    sc <= 1'b0;
    op(OP_SKIP, 16'h0000);
    chk("skip not taken", 16'h1, 16'(cyc));
    $display("test branch done");
  endtask
  task automatic t_speed;
    // Cycles after an accept belong to the op just accepted, so the speed op
    // itself is timed by the check after it, at the new divisor
    for (int c = 0; c < 15; c++) begin
      op(OP_SPEED, {8'h00, 4'(c), 4'h0});
      chk("speed op cycles", 16'(dv[c]), 16'(cyc));
      op(OP_NOP, 16'h0000);
      chk("divisor", 16'(dv[c]), 16'(cyc));
    end
    rdchk(REG_CUR_SPEED, 8'hE0, "speed value");
    op(OP_SPEED, 16'h0000);
    @(posedge clk);
    ffl <= 1'b1;
    op(OP_NOP, 16'h0000);
    chk("flash divisor", 16'(FLASH_DIV_CYC), 16'(cyc));
    rdchk(REG_CUR_SPEED, 8'h00, "flash speed reg");
    @(posedge clk);
    ffl <= 1'b0;
    for (int s = 2; s >= 0; s--) begin
      op(OP_SPEED, {12'h000, 2'(s), 2'h0});
      chk("clock source", 16'(s), {14'h0000, src});
      chk("switch delay", 16'h0005, 16'(cyc));
    end
    op(OP_SPEED, 16'h0003);
    chk("osc mult off", 16'h0003, {14'h0000, mo, oo});
    op(OP_SPEED, 16'h0000);
    chk("wake delay", 16'h0005, 16'(cyc));
    $display("test speed done");
  endtask
  task automatic t_mem;
    int base;
    wr(REG_ADDR_LOW, 8'h34);
    wr(REG_ADDR_HIGH, 8'h12);
    op(OP_FREAD, 16'h0000);
    chk("flash addr", 16'h1234, fa);
    cyc = 0;
    while (fv !== 1'b1 && cyc < 50) begin
      @(negedge clk);
      cyc++;
    end
    if (cyc >= 50) hang("flash");
    rdchk(REG_DATA_HIGH, 8'h48, "data high");
    rdchk(REG_DATA_LOW, 8'hF7, "data low");
    wr(REG_ADDR_LOW, 8'h10);
    wr(REG_ADDR_HIGH, 8'h00);
    wr(REG_DATA_LOW, 8'hEF);
    wr(REG_DATA_HIGH, 8'hBE);
    base = n_wr;
    op(OP_IWRITE, 16'h0000);
    chk("iwrite cycles", 16'h4, 16'(cyc));
    chk("ram word", 16'hBEEF, mw);
    chk("ram addr", 16'h0010, ma);
    wr(REG_DATA_HIGH, 8'h00);
    op(OP_IREAD, 16'h0000);
    chk("iread cycles", 16'h4, 16'(cyc));
    rdchk(REG_DATA_HIGH, 8'hBE, "iread high");
    wr(REG_ADDR_HIGH, 8'h09);
    op(OP_IWRITE, 16'h0000);
    chk("ram writes", 16'h1, 16'(n_wr - base));
    op(OP_MUL, 16'h0000);
    chk("mul cycles", 16'h1, 16'(cyc));
    $display("test memory done");
  endtask
  task automatic t_irq;
    wr(REG_ISR_SPEED, 8'h10);
    wr(REG_VECTOR_LOW, 8'h40);
    wr(REG_VECTOR_HIGH, 8'hE1);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      irq <= 1'b1; keep <= k[0]; ret <= 16'h2210;
      cyc = 0;
      while (isr !== 1'b1 && cyc < 100) begin
        @(negedge clk);
        cyc++;
      end
      if (cyc >= 100) hang("interrupt");
      @(posedge clk);
      irq <= 1'b0;
      rdchk(REG_CUR_SPEED, 8'h10, "isr speed");
      chk("vector pc", 16'hE140, pc);
      chk("isr page", 16'h7, {13'h0000, pg});
      op(OP_NOP, 16'h0000);
      chk("isr divisor", 16'h2, 16'(cyc));
      op(OP_RETI, 16'h0000);
      chk("reti pc", 16'h2210, pc);
      chk("reti page", 16'h1, {13'h0000, pg});
      rdchk(REG_CUR_SPEED, k ? 8'h10 : 8'h00, "reti speed");
    end
    $display("test interrupt done");
  endtask
  task automatic t_stop;
    @(posedge clk);
    opk <= OP_SPEED;
    opnd <= 16'h00F0;
    opv <= 1'b1;
    wait_rdy();
    @(posedge clk);
    opv <= 1'b0;
    repeat (8) begin
      @(negedge clk);
      chk("stopped tick", 16'h0000, {15'h0000, tk});
    end
    $display("test stop done");
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'b1; we = 1'b0; re = 1'b0; ra = 4'h0; wd = 8'h00;
    opv = 1'b0; opk = OP_NOP; opnd = 16'h0000; sc = 1'b0; irq = 1'b0;
    ret = 16'h2150; keep = 1'b0; ffl = 1'b0;
    sx = 1'b0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_branch();
    t_speed();
    t_mem();
    t_irq();
    t_stop();
    stop_test();
  end
endmodule
`default_nettype wire
